// ---- logic/reload_timer_pkg.sv ----
// constants for the 8-bit reload/event timer: register indices, fields, resets
// assumes a 40 MHz system clock; byte address of a register is 4 x its index
// Notes on behaviour
// - source codes 0..6 pick prescaler taps 2048..2 cycles, code 7 the event pin
// - in low-speed operation with cycle select set, each tap period is halved
// - capture/edge mode is three write-only bits, cleared by reset and stop mode
// - capture enable low: free-running or reload timer; high: wrapping timer, no reload and no read latch
// - edge select: 00 none, 01 falling, 10 rising, 11 both edges
// - counter is an 8-bit up counter, one step per selected tick
// - overflow sets the timer interrupt request flag
// - overflow with reload select low wraps the counter to zero
// - overflow with reload select high and capture enable low loads the written reload pair
// - counter clears to zero on reset and in stop mode
// - counter reached only through the read pair and the write pair
// - writing the low write nibble only holds it, counter unchanged
// - writing the high nibble loads counter high, held low nibble to counter low
// - held low nibble persists, so a lone high write reloads the counter
// - reset clears both write nibbles; stop clears the low one and leaves the high one alone
// - reading the high read nibble latches the low one while capture enable is low; read high first
package reload_timer_pkg;

    localparam logic [7:0] IDX_RELOAD_LOW      = 8'h0A;
    localparam logic [7:0] IDX_RELOAD_HIGH     = 8'h0B;
    localparam logic [7:0] IDX_CAPTURE_EDGE    = 8'h26;
    localparam logic [7:0] IDX_TIMER_MODE      = 8'h30;
    localparam logic [7:0] IDX_POWER_CTRL      = 8'h31;
    localparam logic [7:0] IDX_IRQ_STATUS      = 8'h32;
    localparam logic [7:0] IDX_IRQ_CLEAR       = 8'h33;
    localparam logic [7:0] IDX_IRQ_ENABLE      = 8'h34;

    localparam int unsigned MODE_SRC_LSB       = 0;
    localparam int unsigned MODE_RELOAD_BIT    = 3;
    localparam int unsigned CAP_EN_BIT         = 2;
    localparam int unsigned EDGE_LSB           = 0;
    localparam int unsigned PWR_STOP_BIT       = 0;
    localparam int unsigned PWR_SUB_BIT        = 1;
    localparam int unsigned PWR_LSS_BIT        = 2;
    localparam int unsigned IRQ_OVF_BIT        = 0;
    localparam int unsigned IRQ_EDGE_BIT       = 1;

    localparam logic [7:0] COUNTER_RST         = 8'h00;
    localparam logic [3:0] RELOAD_LOW_RST      = 4'h0;
    localparam logic [3:0] RELOAD_HIGH_RST     = 4'h0;
    localparam logic [2:0] CAPTURE_EDGE_RST    = 3'h0;
    localparam logic [3:0] TIMER_MODE_RST      = 4'h0;
    localparam logic [2:0] POWER_CTRL_RST      = 3'h0;
    localparam logic [1:0] IRQ_RST             = 2'h0;
    localparam logic [7:0] COUNTER_MAX         = 8'hFF;

    localparam logic [2:0] SRC_EXTERNAL        = 3'h7;
    localparam logic [1:0] EDGE_NONE           = 2'h0;
    localparam logic [1:0] EDGE_FALL           = 2'h1;
    localparam logic [1:0] EDGE_RISE           = 2'h2;
    localparam logic [1:0] EDGE_BOTH           = 2'h3;

    // log2 of tap period in instruction cycles, per source code; entry 7 unused
    localparam logic [3:0] TAP_LOG2 [8] = '{4'hB, 4'h9, 4'h7, 4'h5, 4'h3, 4'h2, 4'h1, 4'h0};
    localparam int unsigned PRESCALER_W        = 11;
    localparam int unsigned CYCLE_DIV_DEFAULT  = 4;

endpackage : reload_timer_pkg

// ---- logic/reload_event_timer.sv ----
// 8-bit up-counting timer with prescaler/event tick, wrap or reload, nibble load path
// assumes an Avalon-MM master on clk_sys_i and an asynchronous event pin
//
// Our own choice: the Avalon-MM register port.
`timescale 1ns/1ps
module reload_event_timer #(
    parameter int unsigned CYCLE_DIV = reload_timer_pkg::CYCLE_DIV_DEFAULT
) (
    input  wire logic        clk_sys_i,             // 40 MHz system clock
    input  wire logic        reset_n_i,             // async reset, active low
    input  wire logic        ce_i,                  // clock enable, freezes all state
    input  wire logic [9:0]  avs_address_i,         // byte address
    input  wire logic        avs_read_i,            // read request
    input  wire logic        avs_write_i,           // write request
    input  wire logic [31:0] avs_writedata_i,       // write data
    input  wire logic [3:0]  avs_byteenable_i,      // byte enables
    output logic      [31:0] avs_readdata_o,        // read data
    output logic             avs_waitrequest_o,     // stall, high when idle
    input  wire logic        external_event_pin_i,  // asynchronous event input
    output logic             irq_o                  // level interrupt
);

    localparam int unsigned CDW = (CYCLE_DIV > 1) ? $clog2(CYCLE_DIV) : 1;
    localparam logic [CDW-1:0] CYC_LAST = CDW'(CYCLE_DIV - 1);
    localparam int unsigned PW = reload_timer_pkg::PRESCALER_W;

    if (CYCLE_DIV < 1 || CYCLE_DIV > 65536)
    begin : g_bad_div
        $error("CYCLE_DIV out of range");
    end

    logic [7:0]    up_counter_value;
    logic [3:0]    reload_low_nibble_write;
    logic [3:0]    reload_high_nibble_write;
    logic [2:0]    capture_edge_mode;
    logic [3:0]    timer_mode_first;
    logic [2:0]    power_ctrl;
    logic [3:0]    count_low_nibble_read;
    logic [1:0]    irq_status;
    logic [1:0]    irq_enable;
    logic [CDW-1:0] cyc_cnt;
    logic [PW-1:0] system_prescaler;
    logic [2:0]    evt_sync;
    logic          evt_level;
    logic [7:0]    next_counter;
    logic [31:0]   next_readdata;

    // bus decode
    wire [7:0] reg_idx     = avs_address_i[9:2];
    wire       bus_req     = avs_read_i | avs_write_i;
    wire       first_edge  = ce_i & bus_req & avs_waitrequest_o;
    wire       accept      = ce_i & bus_req & ~avs_waitrequest_o;
    wire       wr_acc      = accept & avs_write_i & avs_byteenable_i[0];
    wire       sel_low     = reg_idx == reload_timer_pkg::IDX_RELOAD_LOW;
    wire       sel_high    = reg_idx == reload_timer_pkg::IDX_RELOAD_HIGH;
    wire       sel_cap     = reg_idx == reload_timer_pkg::IDX_CAPTURE_EDGE;
    wire       sel_mode    = reg_idx == reload_timer_pkg::IDX_TIMER_MODE;
    wire       sel_pwr     = reg_idx == reload_timer_pkg::IDX_POWER_CTRL;
    wire       sel_stat    = reg_idx == reload_timer_pkg::IDX_IRQ_STATUS;
    wire       sel_clr     = reg_idx == reload_timer_pkg::IDX_IRQ_CLEAR;
    wire       sel_en      = reg_idx == reload_timer_pkg::IDX_IRQ_ENABLE;
    wire       wr_low      = wr_acc & sel_low;
    wire       wr_high     = wr_acc & sel_high;
    wire       wr_clr      = wr_acc & sel_clr;
    wire       wr_en       = wr_acc & sel_en;
    wire [3:0] wnib        = avs_writedata_i[3:0];

    // control fields
    wire       stop_mode   = power_ctrl[reload_timer_pkg::PWR_STOP_BIT];
    wire       subactive   = power_ctrl[reload_timer_pkg::PWR_SUB_BIT];
    wire       low_speed_cycle_select = power_ctrl[reload_timer_pkg::PWR_LSS_BIT];
    wire [2:0] tick_source_select = timer_mode_first[reload_timer_pkg::MODE_SRC_LSB +: 3];
    wire       wrap_or_reload_select = timer_mode_first[reload_timer_pkg::MODE_RELOAD_BIT];
    wire       capture_enable = capture_edge_mode[reload_timer_pkg::CAP_EN_BIT];
    wire [1:0] edge_type_select = capture_edge_mode[reload_timer_pkg::EDGE_LSB +: 2];

    // instruction-cycle strobe and tap selection
    wire          cyc_en    = cyc_cnt == CYC_LAST;
    wire [3:0]    tap_full  = reload_timer_pkg::TAP_LOG2[tick_source_select];
    wire          halve     = subactive & low_speed_cycle_select;
    wire [3:0]    tap_used  = tap_full - {3'h0, halve};
    wire [PW:0]   tap_span  = (PW+1)'(1) << tap_used;
    wire [PW-1:0] tap_mask  = PW'(tap_span - (PW+1)'(1));
    wire          psc_tick  = cyc_en & (&(system_prescaler | ~tap_mask));

    // event pin: level accepted once second and third stages agree
    wire evt_stable = evt_sync[1] == evt_sync[2];
    wire evt_rise   = evt_stable & evt_sync[2] & ~evt_level;
    wire evt_fall   = evt_stable & ~evt_sync[2] & evt_level;
    wire edge_hit   = (evt_fall & edge_type_select[0])
                    | (evt_rise & edge_type_select[1]);

    wire ext_src    = tick_source_select == reload_timer_pkg::SRC_EXTERNAL;
    wire tick       = ext_src ? edge_hit : psc_tick;
    wire at_max     = up_counter_value == reload_timer_pkg::COUNTER_MAX;
    wire overflow   = tick & at_max;
    // capture mode keeps wrapping; no capture latching path exists in this timer
    wire reload_mode = wrap_or_reload_select & ~capture_enable;
    wire [7:0] reload_value = {reload_high_nibble_write, reload_low_nibble_write};

    wire [1:0] irq_events = {edge_hit, overflow};
    wire [1:0] clr_mask   = wr_clr ? avs_writedata_i[1:0] : 2'h0;
    wire [1:0] next_status = (irq_status & ~clr_mask) | irq_events;
    wire [1:0] next_enable = wr_en ? avs_writedata_i[1:0] : irq_enable;
    wire       rd_high    = first_edge & avs_read_i & sel_high;

    always_comb
    begin
        if (stop_mode)
            next_counter = reload_timer_pkg::COUNTER_RST;
        else if (wr_high)
            next_counter = {wnib, reload_low_nibble_write};
        else if (overflow && reload_mode)
            next_counter = reload_value;
        else if (overflow)
            next_counter = reload_timer_pkg::COUNTER_RST;
        else if (tick)
            next_counter = up_counter_value + 8'h01;
        else
            next_counter = up_counter_value;
    end

    // counter itself has no address; only the nibble pairs reach it
    always_comb
    begin
        next_readdata = 32'h0;
        if (sel_low)
            next_readdata = {28'h0, count_low_nibble_read};
        else if (sel_high)
            next_readdata = {28'h0, up_counter_value[7:4]};
        else if (sel_mode)
            next_readdata = {28'h0, timer_mode_first};
        else if (sel_pwr)
            next_readdata = {29'h0, power_ctrl};
        else if (sel_stat)
            next_readdata = {30'h0, irq_status};
        else if (sel_en)
            next_readdata = {30'h0, irq_enable};
    end

    // answer one edge after the request is seen; writes act at the accept edge, reads at the first edge
    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            avs_waitrequest_o <= 1'b1;
            avs_readdata_o    <= 32'h0;
        end
        else if (ce_i)
        begin
            avs_waitrequest_o <= ~(bus_req & avs_waitrequest_o);
            if (first_edge && avs_read_i)
                avs_readdata_o <= next_readdata;
        end
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            cyc_cnt          <= '0;
            system_prescaler <= '0;
        end
        else if (ce_i)
        begin
            cyc_cnt <= cyc_en ? '0 : cyc_cnt + CDW'(1);
            if (cyc_en)
                system_prescaler <= system_prescaler + PW'(1);
        end
    end

    // third stage and stable level: a glitch shorter than a cycle is not an edge
    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            evt_sync  <= 3'h0;
            evt_level <= 1'b0;
        end
        else if (ce_i)
        begin
            evt_sync <= {evt_sync[1:0], external_event_pin_i};
            if (evt_stable)
                evt_level <= evt_sync[2];
        end
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            up_counter_value        <= reload_timer_pkg::COUNTER_RST;
            reload_low_nibble_write <= reload_timer_pkg::RELOAD_LOW_RST;
            capture_edge_mode       <= reload_timer_pkg::CAPTURE_EDGE_RST;
            count_low_nibble_read   <= 4'h0;
        end
        else if (ce_i)
        begin
            up_counter_value <= next_counter;
            if (stop_mode)
            begin
                reload_low_nibble_write <= reload_timer_pkg::RELOAD_LOW_RST;
                capture_edge_mode       <= reload_timer_pkg::CAPTURE_EDGE_RST;
            end
            else
            begin
                if (wr_low)
                    reload_low_nibble_write <= wnib;
                if (wr_acc && sel_cap)
                    capture_edge_mode <= avs_writedata_i[2:0];
            end
            if (rd_high && !capture_enable)
                count_low_nibble_read <= up_counter_value[3:0];
        end
    end

    // high write nibble has no stop clear: stop mode leaves it as it was
    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            reload_high_nibble_write <= reload_timer_pkg::RELOAD_HIGH_RST;
        else if (ce_i && wr_high)
            reload_high_nibble_write <= wnib;
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            timer_mode_first <= reload_timer_pkg::TIMER_MODE_RST;
            power_ctrl       <= reload_timer_pkg::POWER_CTRL_RST;
            irq_status       <= reload_timer_pkg::IRQ_RST;
            irq_enable       <= reload_timer_pkg::IRQ_RST;
            irq_o            <= 1'b0;
        end
        else if (ce_i)
        begin
            if (wr_acc && sel_mode)
                timer_mode_first <= avs_writedata_i[3:0];
            if (wr_acc && sel_pwr)
                power_ctrl <= avs_writedata_i[2:0];
            irq_status <= next_status;
            irq_enable <= next_enable;
            irq_o      <= |(next_status & next_enable);
        end
    end

    // checks
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!reset_n_i);

    sequence s_tick_step;
        ce_i && tick && !at_max && !stop_mode && !wr_high;
    endsequence
    sequence s_overflow;
        ce_i && overflow && !stop_mode && !wr_high;
    endsequence
    sequence s_bus_first;
        bus_req && avs_waitrequest_o && ce_i;
    endsequence

    property p_count_step;
        s_tick_step |=> up_counter_value == $past(up_counter_value) + 8'h01;
    endproperty
    a_count_step: assert property (p_count_step)
        else $error("counter did not step on tick");

    property p_wrap;
        s_overflow ##0 !reload_mode |=> up_counter_value == 8'h00;
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("counter did not wrap to zero");

    property p_reload;
        s_overflow ##0 reload_mode |=> up_counter_value == $past(reload_value);
    endproperty
    a_reload: assert property (p_reload)
        else $error("counter did not take reload value");

    property p_irq_flag;
        s_overflow |=> irq_status[reload_timer_pkg::IRQ_OVF_BIT] && (irq_o || !irq_enable[0]);
    endproperty
    a_irq_flag: assert property (p_irq_flag)
        else $error("overflow flag not set");

    property p_low_hold;
        ce_i && wr_low && !tick && !stop_mode |=>
            up_counter_value == $past(up_counter_value)
            && reload_low_nibble_write == $past(wnib);
    endproperty
    a_low_hold: assert property (p_low_hold)
        else $error("low nibble write disturbed counter");

    property p_high_load;
        ce_i && wr_high && !stop_mode |=>
            up_counter_value == {$past(wnib), $past(reload_low_nibble_write)};
    endproperty
    a_high_load: assert property (p_high_load)
        else $error("high nibble write load wrong");

    property p_stop_clear;
        ce_i && stop_mode |=> up_counter_value == 8'h00
            && reload_low_nibble_write == 4'h0 && capture_edge_mode == 3'h0;
    endproperty
    a_stop_clear: assert property (p_stop_clear)
        else $error("stop mode did not clear state");

    property p_read_latch;
        ce_i && rd_high && !capture_enable |=>
            count_low_nibble_read == $past(up_counter_value[3:0])
            && avs_readdata_o[3:0] == $past(up_counter_value[7:4]);
    endproperty
    a_read_latch: assert property (p_read_latch)
        else $error("high read did not latch low nibble");

    property p_edge_type;
        ce_i && edge_type_select == reload_timer_pkg::EDGE_NONE |-> !edge_hit;
    endproperty
    a_edge_type: assert property (p_edge_type)
        else $error("edge seen with detection off");

    property p_bus_answer;
        s_bus_first |=> !avs_waitrequest_o;
    endproperty
    a_bus_answer: assert property (p_bus_answer)
        else $error("bus request not answered in one cycle");

    property p_bus_one_cycle;
        ce_i && !avs_waitrequest_o |=> avs_waitrequest_o;
    endproperty
    a_bus_one_cycle: assert property (p_bus_one_cycle)
        else $error("waitrequest low for more than one cycle");

    // the prescaler must freeze too, or tap phase drifts across a pause
    property p_freeze;
        !ce_i |=> $stable(up_counter_value) && $stable(system_prescaler)
            && $stable(avs_waitrequest_o) && $stable(irq_status);
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("state moved with clock enable low");

    property p_clear_or_set;
        ce_i && wr_clr && avs_writedata_i[reload_timer_pkg::IRQ_OVF_BIT] |=>
            irq_status[reload_timer_pkg::IRQ_OVF_BIT] == $past(overflow);
    endproperty
    a_clear_or_set: assert property (p_clear_or_set)
        else $error("overflow flag clear or set-wins wrong");

    property p_edge_once;
        ce_i && edge_hit |=> evt_level != $past(evt_level);
    endproperty
    a_edge_once: assert property (p_edge_once)
        else $error("edge not consumed by level update");

    property p_stop_keeps_high;
        ce_i && stop_mode && !wr_high |=> $stable(reload_high_nibble_write);
    endproperty
    a_stop_keeps_high: assert property (p_stop_keeps_high)
        else $error("stop mode disturbed high write nibble");

    property p_mode_write;
        ce_i && wr_acc && sel_cap && !stop_mode |=>
            capture_edge_mode == $past(avs_writedata_i[2:0]);
    endproperty
    a_mode_write: assert property (p_mode_write)
        else $error("capture and edge mode write lost");

    // a tap of two or more cycles never fires on two edges in a row unless the mode or power register is written
    property p_tick_gap;
        ce_i && psc_tick && tap_used != 4'h0 && !(wr_acc && (sel_mode || sel_pwr))
            |=> !psc_tick;
    endproperty
    a_tick_gap: assert property (p_tick_gap)
        else $error("prescaler tap fired twice in a row");

endmodule : reload_event_timer

// ---- test/tb_eight_bit_reload_event_timer.sv ----
// self-checking bench for the reload/event timer: bus tasks, row loops, hand tests
// assumes CYCLE_DIV of 1 so one instruction cycle is one system clock
`timescale 1ns/1ps
module tb_eight_bit_reload_event_timer;
    typedef struct { logic [2:0] src; logic [2:0] pwr; int cyc; int exp; } tap_row_t;
    typedef struct { logic [1:0] sel; logic [7:0] exp; } edge_row_t;
    logic        clk_sys_i;
    logic        reset_n_i;
    logic        ce_i;
    logic [9:0]  avs_address_i;
    logic        avs_read_i;
    logic        avs_write_i;
    logic [31:0] avs_writedata_i;
    logic [3:0]  avs_byteenable_i;
    logic [31:0] avs_readdata_o;
    logic        avs_waitrequest_o;
    logic        external_event_pin_i;
    logic        irq_o;
    logic [31:0] d;
    logic [7:0]  c;
    int          fails;
    int          checked;
    // window of four tap periods; halving shows as a shorter window for the same count
    tap_row_t taps [9] = '{'{3'h0, 3'h0, 8192, 4}, '{3'h1, 3'h0, 2048, 4},
        '{3'h2, 3'h0, 512, 4}, '{3'h3, 3'h0, 128, 4}, '{3'h4, 3'h0, 32, 4},
        '{3'h5, 3'h0, 16, 4}, '{3'h6, 3'h0, 8, 4}, '{3'h3, 3'h2, 128, 4},
        '{3'h3, 3'h6, 64, 4}};
    edge_row_t edges [4] = '{'{2'h0, 8'h00}, '{2'h1, 8'h01}, '{2'h2, 8'h01}, '{2'h3, 8'h02}};

    reload_event_timer #(.CYCLE_DIV(1)) DUT (
        .clk_sys_i            (clk_sys_i),
        .reset_n_i            (reset_n_i),
        .ce_i                 (ce_i),
        .avs_address_i        (avs_address_i),
        .avs_read_i           (avs_read_i),
        .avs_write_i          (avs_write_i),
        .avs_writedata_i      (avs_writedata_i),
        .avs_byteenable_i     (avs_byteenable_i),
        .avs_readdata_o       (avs_readdata_o),
        .avs_waitrequest_o    (avs_waitrequest_o),
        .external_event_pin_i (external_event_pin_i),
        .irq_o                (irq_o)
    );

    initial
    begin
        clk_sys_i = 1'b0;
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end

    task conclude;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : conclude

    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            fails++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // request held until waitrequest is sampled low; data taken at that edge
    task bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
             output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge clk_sys_i);
        avs_address_i   <= {idx, 2'b00};
        avs_writedata_i <= wd;
        avs_write_i     <= wr;
        avs_read_i      <= ~wr;
        do
        begin
            @(posedge clk_sys_i);
            n++;
        end
        while (avs_waitrequest_o !== 1'b0);
        check("bus latency", n, 2);
        rd = avs_readdata_o;
        avs_read_i  <= 1'b0;
        avs_write_i <= 1'b0;
    endtask : bus

    task wreg(input logic [7:0] idx, input logic [31:0] wd);
        logic [31:0] t;
        bus(1'b1, idx, wd, t);
    endtask : wreg

    task rcount(output logic [7:0] v);
        logic [31:0] hi;
        logic [31:0] lo;
        bus(1'b0, reload_timer_pkg::IDX_RELOAD_HIGH, 32'h0, hi);
        bus(1'b0, reload_timer_pkg::IDX_RELOAD_LOW, 32'h0, lo);
        v = {hi[3:0], lo[3:0]};
    endtask : rcount

    task load(input logic [7:0] v);
        wreg(reload_timer_pkg::IDX_RELOAD_LOW, {28'h0, v[3:0]});
        wreg(reload_timer_pkg::IDX_RELOAD_HIGH, {28'h0, v[7:4]});
    endtask : load

    // slow pulses so the synchroniser sees each level for several cycles
    task pulse(input int n);
        repeat (n)
        begin
            @(posedge clk_sys_i);
            external_event_pin_i <= 1'b1;
            repeat (6) @(posedge clk_sys_i);
            external_event_pin_i <= 1'b0;
            repeat (6) @(posedge clk_sys_i);
        end
    endtask : pulse

    initial
    begin
        // the tap rows need about 11k cycles; everything else a few hundred
        repeat (50000) @(posedge clk_sys_i);
        fails++;
        conclude();
    end

    initial
    begin
        reset_n_i = 1'b0;
        ce_i = 1'b1;
        avs_address_i = 10'h000;
        avs_read_i = 1'b0;
        avs_write_i = 1'b0;
        avs_writedata_i = 32'h0;
        avs_byteenable_i = 4'hF;
        external_event_pin_i = 1'b0;
        fails = 0;
        checked = 0;
        repeat (12) @(posedge clk_sys_i);
        #1;
        check("irq_o reset", irq_o, 1'b0);
        check("waitrequest reset", avs_waitrequest_o, 1'b1);
        @(posedge clk_sys_i);
        reset_n_i <= 1'b1;
        bus(1'b0, reload_timer_pkg::IDX_TIMER_MODE, 32'h0, d);
        check("mode reset", d, 32'h0);
        bus(1'b0, reload_timer_pkg::IDX_IRQ_STATUS, 32'h0, d);
        check("status reset", d, 32'h0);
        rcount(c);
        check("counter reset", c, 8'h00);
        bus(1'b0, 8'h3F, 32'h0, d);
        check("unmapped", d, 32'h0);
        $display("test reset done");
        foreach (taps[i])
        begin
            wreg(reload_timer_pkg::IDX_POWER_CTRL, {29'h0, taps[i].pwr});
            wreg(reload_timer_pkg::IDX_TIMER_MODE, {29'h0, taps[i].src});
            load(8'h00);
            repeat (taps[i].cyc) @(posedge clk_sys_i);
            rcount(c);
            // bus latency may cost one tick or add up to two
            check("tap count", c >= taps[i].exp-1 && c <= taps[i].exp+2, 1'b1);
            check("tap moved", c != 8'h00, 1'b1);
        end
        wreg(reload_timer_pkg::IDX_POWER_CTRL, 32'h0);
        $display("test taps done");
        wreg(reload_timer_pkg::IDX_TIMER_MODE, {29'h0, reload_timer_pkg::SRC_EXTERNAL});
        foreach (edges[i])
        begin
            wreg(reload_timer_pkg::IDX_CAPTURE_EDGE, {30'h0, edges[i].sel});
            load(8'h00);
            pulse(1);
            rcount(c);
            check("edge count", c, edges[i].exp);
        end
        $display("test edges done");
        wreg(reload_timer_pkg::IDX_CAPTURE_EDGE, {30'h0, reload_timer_pkg::EDGE_RISE});
        bus(1'b0, reload_timer_pkg::IDX_CAPTURE_EDGE, 32'h0, d);
        check("mode write only", d, 32'h0);
        wreg(reload_timer_pkg::IDX_IRQ_ENABLE, 32'h0);
        load(8'hFE);
        pulse(2);
        rcount(c);
        check("wrap", c, 8'h00);
        bus(1'b0, reload_timer_pkg::IDX_IRQ_STATUS, 32'h0, d);
        check("overflow flag", d[0], 1'b1);
        check("irq masked", irq_o, 1'b0);
        wreg(reload_timer_pkg::IDX_IRQ_ENABLE, 32'h1);
        repeat (2) @(posedge clk_sys_i);
        check("irq enabled", irq_o, 1'b1);
        wreg(reload_timer_pkg::IDX_IRQ_CLEAR, 32'h1);
        repeat (2) @(posedge clk_sys_i);
        check("irq cleared", irq_o, 1'b0);
        $display("test overflow done");
        wreg(reload_timer_pkg::IDX_TIMER_MODE, 32'hF);
        load(8'hF5);
        pulse(11);
        rcount(c);
        check("reload", c, 8'hF5);
        wreg(reload_timer_pkg::IDX_RELOAD_HIGH, 32'hA);
        rcount(c);
        check("lone high write", c, 8'hA5);
        wreg(reload_timer_pkg::IDX_RELOAD_LOW, 32'h3);
        rcount(c);
        check("low write holds", c, 8'hA5);
        bus(1'b0, reload_timer_pkg::IDX_RELOAD_HIGH, 32'h0, d);
        pulse(1);
        bus(1'b0, reload_timer_pkg::IDX_RELOAD_LOW, 32'h0, d);
        check("latched low", d[3:0], 4'h5);
        avs_byteenable_i <= 4'h0;
        wreg(reload_timer_pkg::IDX_RELOAD_HIGH, 32'h2);
        avs_byteenable_i <= 4'hF;
        rcount(c);
        check("byteenable off", c, 8'hA6);
        $display("test reload done");
        wreg(reload_timer_pkg::IDX_POWER_CTRL, 32'h1);
        wreg(reload_timer_pkg::IDX_POWER_CTRL, 32'h0);
        rcount(c);
        check("stop clears counter", c, 8'h00);
        wreg(reload_timer_pkg::IDX_RELOAD_HIGH, 32'h7);
        rcount(c);
        check("stop clears low", c, 8'h70);
        pulse(1);
        rcount(c);
        check("stop clears edge", c, 8'h70);
        $display("test stop done");
        // tap of two cycles: only the edges either side of the pause may tick, exactly one does
        wreg(reload_timer_pkg::IDX_TIMER_MODE, 32'h6);
        load(8'h10);
        @(posedge clk_sys_i);
        ce_i <= 1'b0;
        repeat (20) @(posedge clk_sys_i);
        ce_i <= 1'b1;
        rcount(c);
        check("clock enable freeze", c, 8'h11);
        $display("test freeze done");
        conclude();
    end
endmodule : tb_eight_bit_reload_event_timer
